// file: hdl/adc_seq_params.svh
`ifndef ADC_SEQ_PARAMS_SVH
`define ADC_SEQ_PARAMS_SVH

// register byte addresses
`define ADDR_CONTROL_ONE   12'h000
`define ADDR_CONTROL_TWO   12'h004
`define ADDR_CONTROL_THREE 12'h008

// reset values
`define RESET_CONTROL_ONE   16'h0000
`define RESET_CONTROL_TWO   16'h0000
`define RESET_CONTROL_THREE 16'h0000

// control one fields
`define POS_TWELVE_BIT     10
`define POS_TRIGGER_LO     5
`define POS_SIMULTANEOUS   3
`define POS_AUTO_SAMPLE    2
`define POS_SAMPLING       1
`define POS_DONE           0

// control two fields
`define POS_REF_LO         13
`define POS_SCAN           10
`define POS_COUNT_LO       8
`define POS_BUF_HALF       7
`define POS_RATE_LO        2
`define POS_SPLIT          1
`define POS_ALTERNATE      0

// control three fields
`define POS_CLOCK_SOURCE   15

// timing: conversion and follow-on sample times in ns, at 50 MHz
`define CLK_PERIOD_NS      20
`define CONVERT_TIME_NS    280
`define RESAMPLE_TIME_NS   100
`define CONVERT_CYCLES     (`CONVERT_TIME_NS / `CLK_PERIOD_NS)
`define RESAMPLE_CYCLES    ((`RESAMPLE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// file: hdl/adc_seq_pkg.sv
package adc_seq_pkg;

  // sequencer states, gray along idle-sample-convert-resample
  typedef enum logic [1:0]
  {
    st_idle     = 2'b00,
    st_sample   = 2'b01,
    st_convert  = 2'b11,
    st_resample = 2'b10
  } seq_state_t;

  typedef logic [15:0] reg16_t;

endpackage

// file: hdl/op_counter.sv
`timescale 1ns/1ps
`include "adc_seq_params.svh"

module op_counter
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // control
  input  wire logic       op_done,
  input  wire logic [3:0] increment_rate,
  input  wire logic       split_buffer_mode,
  // results
  output logic            advance,
  output logic            buffer_half_status,
  output logic [3:0]      op_count
);

  // -----------------------------------------
  // operations per advance
  // -----------------------------------------
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      op_count <= 4'h0;
    else if (op_done)
    begin
      if (op_count >= increment_rate)
        op_count <= 4'h0;
      else
        op_count <= op_count + 4'h1;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      advance <= 1'b0;
    else
      advance <= op_done && (op_count >= increment_rate);
  end

  // -----------------------------------------
  // buffer half
  // -----------------------------------------
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      buffer_half_status <= 1'b0;
    else if (!split_buffer_mode)
      buffer_half_status <= 1'b0;
    else if (op_done && (op_count >= increment_rate))
      buffer_half_status <= ~buffer_half_status;
  end

endmodule

// file: hdl/adc_seq.sv
// The register offsets and the APB slave port were left to the implementer.
`timescale 1ns/1ps
`include "adc_seq_params.svh"

module adc_seq
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // trigger pin
  input  wire logic        conversion_trigger,
  // analog front end control
  output logic [3:0]       sample_hold_sampling,
  output logic             convert_active,
  output logic [1:0]       convert_channel,
  output logic             select_sample_b,
  output logic             scan_active,
  output logic             ref_positive_external,
  output logic             ref_negative_external,
  output logic             conversion_clock_source,
  // buffer side
  output logic             op_complete,
  output logic             dma_advance,
  output logic             buffer_half_status
);

  // -----------------------------------------
  // functions
  // -----------------------------------------
  function automatic logic [2:0] last_channel(input logic [1:0] count);
    begin
      if (count[1])
        last_channel = 3'd3;
      else if (count[0])
        last_channel = 3'd1;
      else
        last_channel = 3'd0;
    end
  endfunction

  function automatic logic [1:0] ref_decode(input logic [2:0] sel);
    begin
      case (sel)
        3'b001:  ref_decode = 2'b10;
        3'b010:  ref_decode = 2'b01;
        3'b011:  ref_decode = 2'b11;
        default: ref_decode = 2'b00;
      endcase
    end
  endfunction

  // -----------------------------------------
  // registers
  // -----------------------------------------
  adc_seq_pkg::reg16_t     control_one;
  adc_seq_pkg::reg16_t     control_two;
  adc_seq_pkg::reg16_t     control_three;
  adc_seq_pkg::seq_state_t state;
  logic                    done_flag;
  logic [2:0]              channel;
  logic [8:0]              timer;
  logic [2:0]              trig_sync;
  logic [1:0]              ref_code;

  // -----------------------------------------
  // field views
  // -----------------------------------------
  logic       twelve_bit_mode;
  logic [2:0] trigger_source;
  logic       simultaneous_sample_select;
  logic       auto_sampling_enable;
  logic [1:0] channel_count;
  logic       scan_enable;
  logic [3:0] increment_rate;
  logic       split_buffer_mode;
  logic       alternate_input_mode;
  logic [2:0] reference_select;
  logic       sampling_active;

  assign twelve_bit_mode      = control_one[`POS_TWELVE_BIT];
  assign trigger_source       = control_one[`POS_TRIGGER_LO +: 3];
  assign auto_sampling_enable = control_one[`POS_AUTO_SAMPLE];
  assign scan_enable          = control_two[`POS_SCAN];
  assign increment_rate       = control_two[`POS_RATE_LO +: 4];
  assign split_buffer_mode    = control_two[`POS_SPLIT];
  assign alternate_input_mode = control_two[`POS_ALTERNATE];
  assign reference_select     = control_two[`POS_REF_LO +: 3];
  assign ref_code             = ref_decode(reference_select);
  assign sampling_active      = (state == adc_seq_pkg::st_sample);
  assign simultaneous_sample_select =
    twelve_bit_mode ? 1'b0 : control_one[`POS_SIMULTANEOUS];
  assign channel_count =
    twelve_bit_mode ? 2'b00 : control_two[`POS_COUNT_LO +: 2];

  // -----------------------------------------
  // apb decode
  // -----------------------------------------
  logic setup_phase;
  logic write_now;
  logic addr_ok;
  logic wr_one;
  logic wr_two;
  logic wr_three;

  assign setup_phase = psel && !penable;
  assign write_now   = psel && penable && pready && pwrite && !pslverr;
  assign addr_ok     = (paddr == `ADDR_CONTROL_ONE) || (paddr == `ADDR_CONTROL_TWO) ||
                       (paddr == `ADDR_CONTROL_THREE);
  assign wr_one      = write_now && (paddr == `ADDR_CONTROL_ONE);
  assign wr_two      = write_now && (paddr == `ADDR_CONTROL_TWO);
  assign wr_three    = write_now && (paddr == `ADDR_CONTROL_THREE);

  logic [15:0] wmask;
  assign wmask = {{8{pstrb[1]}}, {8{pstrb[0]}}};

  logic [15:0] read_one;
  logic [15:0] read_two;
  always_comb
  begin
    read_one                    = control_one;
    read_one[`POS_SIMULTANEOUS] = simultaneous_sample_select;
    read_one[`POS_SAMPLING]     = sampling_active;
    read_one[`POS_DONE]         = done_flag;
    read_two                    = control_two;
    read_two[`POS_COUNT_LO +: 2] = channel_count;
    read_two[`POS_BUF_HALF]     = buffer_half_status;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      pready <= 1'b0;
    else
      pready <= setup_phase;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      pslverr <= 1'b0;
    else
      pslverr <= setup_phase && !addr_ok;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      prdata <= 32'h00000000;
    else if (setup_phase && !pwrite)
    begin
      case (paddr)
        `ADDR_CONTROL_ONE:   prdata <= {16'h0000, read_one};
        `ADDR_CONTROL_TWO:   prdata <= {16'h0000, read_two};
        `ADDR_CONTROL_THREE: prdata <= {16'h0000, control_three};
        default:             prdata <= 32'h00000000;
      endcase
    end
  end

  // -----------------------------------------
  // control registers
  // -----------------------------------------
  localparam logic [15:0] ONE_MASK   = 16'h04EC;
  localparam logic [15:0] TWO_MASK   = 16'hE73F;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      control_one <= `RESET_CONTROL_ONE;
    else if (wr_one)
      control_one <= (control_one & ~(wmask & ONE_MASK)) |
                     (pwdata[15:0] & wmask & ONE_MASK);
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      control_two <= `RESET_CONTROL_TWO;
    else if (wr_two)
      control_two <= (control_two & ~(wmask & TWO_MASK)) |
                     (pwdata[15:0] & wmask & TWO_MASK);
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      control_three <= `RESET_CONTROL_THREE;
    else if (wr_three)
      control_three <= (control_three & ~wmask) | (pwdata[15:0] & wmask);
  end

  // -----------------------------------------
  // software sampling commands
  // -----------------------------------------
  logic sw_start;
  logic sw_end;
  assign sw_start = wr_one && pstrb[0] && pwdata[`POS_SAMPLING] && !auto_sampling_enable;
  assign sw_end   = wr_one && pstrb[0] && !pwdata[`POS_SAMPLING] &&
                    (trigger_source == 3'b000);

  // -----------------------------------------
  // trigger synchroniser
  // -----------------------------------------
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      trig_sync <= 3'b000;
    else
      trig_sync <= {trig_sync[1:0], conversion_trigger};
  end

  logic hw_end;
  assign hw_end = (trigger_source != 3'b000) && trig_sync[1] && !trig_sync[2];

  // -----------------------------------------
  // sequencer
  // -----------------------------------------
  logic timer_zero;
  logic last_conv;
  logic start_conv;
  logic seq_finish;
  assign timer_zero = (timer == 9'd0);
  assign last_conv  = (channel == last_channel(channel_count));
  assign start_conv = (state == adc_seq_pkg::st_sample) && (sw_end || hw_end);
  assign seq_finish = (state == adc_seq_pkg::st_convert) && timer_zero && last_conv;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      state <= adc_seq_pkg::st_idle;
    else
    begin
      case (state)
        adc_seq_pkg::st_idle:
          if (sw_start || auto_sampling_enable)
            state <= adc_seq_pkg::st_sample;
        adc_seq_pkg::st_sample:
          if (start_conv)
            state <= adc_seq_pkg::st_convert;
        adc_seq_pkg::st_convert:
          if (timer_zero)
          begin
            if (!last_conv)
              state <= simultaneous_sample_select ? adc_seq_pkg::st_convert
                                                  : adc_seq_pkg::st_resample;
            else if (auto_sampling_enable)
              state <= adc_seq_pkg::st_sample;
            else
              state <= adc_seq_pkg::st_idle;
          end
        adc_seq_pkg::st_resample:
          if (timer_zero)
            state <= adc_seq_pkg::st_convert;
        default:
          state <= adc_seq_pkg::st_idle;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      timer <= 9'd0;
    else if (start_conv)
      timer <= 9'(`CONVERT_CYCLES - 1);
    else if (state == adc_seq_pkg::st_convert && timer_zero && !last_conv)
      timer <= simultaneous_sample_select ? 9'(`CONVERT_CYCLES - 1)
                                          : 9'(`RESAMPLE_CYCLES - 1);
    else if (state == adc_seq_pkg::st_resample && timer_zero)
      timer <= 9'(`CONVERT_CYCLES - 1);
    else if (!timer_zero)
      timer <= timer - 9'd1;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      channel <= 3'd0;
    else if (start_conv || seq_finish)
      channel <= 3'd0;
    else if (state == adc_seq_pkg::st_convert && timer_zero)
      channel <= channel + 3'd1;
  end

  // -----------------------------------------
  // completion flag
  // -----------------------------------------
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      done_flag <= 1'b0;
    else if (seq_finish)
      done_flag <= 1'b1;
    else if (start_conv)
      done_flag <= 1'b0;
    else if (wr_one && pstrb[0] && !pwdata[`POS_DONE])
      done_flag <= 1'b0;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      op_complete <= 1'b0;
    else
      op_complete <= seq_finish;
  end

  // -----------------------------------------
  // operation counting and buffer halves
  // -----------------------------------------
  op_counter u_op_counter
  (
    .clk                (clk),
    .reset_n            (reset_n),
    .op_done            (seq_finish),
    .increment_rate     (increment_rate),
    .split_buffer_mode  (split_buffer_mode),
    .advance            (dma_advance),
    .buffer_half_status (buffer_half_status),
    .op_count           ()
  );

  // -----------------------------------------
  // input selection
  // -----------------------------------------
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      select_sample_b <= 1'b0;
    else if (!alternate_input_mode)
      select_sample_b <= 1'b0;
    else if (seq_finish)
      select_sample_b <= ~select_sample_b;
  end

  logic next_scan;
  assign next_scan = scan_enable && !(alternate_input_mode && select_sample_b);

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      scan_active <= 1'b0;
    else
      scan_active <= next_scan;
  end

  // -----------------------------------------
  // analog control outputs
  // -----------------------------------------
  logic [3:0] next_sampling;
  always_comb
  begin
    next_sampling = 4'h0;
    if (state == adc_seq_pkg::st_sample)
    begin
      if (simultaneous_sample_select)
        next_sampling = channel_count[1] ? 4'hF : (channel_count[0] ? 4'h3 : 4'h1);
      else
        next_sampling = 4'h1;
    end
    else if (state == adc_seq_pkg::st_resample)
      next_sampling = 4'(4'h1 << channel[1:0]);
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      sample_hold_sampling <= 4'h0;
    else
      sample_hold_sampling <= next_sampling;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      convert_active  <= 1'b0;
      convert_channel <= 2'b00;
    end
    else
    begin
      convert_active  <= (state == adc_seq_pkg::st_convert);
      convert_channel <= channel[1:0];
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ref_positive_external <= 1'b0;
      ref_negative_external <= 1'b0;
    end
    else
    begin
      ref_positive_external <= ref_code[1];
      ref_negative_external <= ref_code[0];
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      conversion_clock_source <= 1'b0;
    else
      conversion_clock_source <= control_three[`POS_CLOCK_SOURCE];
  end

endmodule

// file: sim/adc_seq_assertions.sv
`timescale 1ns/1ps
module adc_seq_assertions
(
  // clock and reset
  input wire logic       clk,
  input wire logic       reset_n,
  // apb
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pwrite,
  input wire logic       pready,
  input wire logic       pslverr,
  // sequencer
  input wire logic [3:0] sample_hold_sampling,
  input wire logic       convert_active,
  input wire logic       op_complete,
  input wire logic       dma_advance,
  input wire logic       ref_positive_external
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  a_error_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_done_single_pulse: assert property (op_complete |=> !op_complete)
    else $error("op_complete longer than one cycle");
  a_hold_in_convert: assert property (convert_active |-> sample_hold_sampling == 4'H0)
    else $error("sampling during conversion");
  a_convert_min_span: assert property ($rose(convert_active) |-> convert_active [*8])
    else $error("conversion cut short");
  a_done_after_convert: assert property (op_complete |->
    $past(convert_active) || $past(convert_active, 2) || $past(convert_active, 3))
    else $error("op_complete without conversion");
  a_advance_after_op: assert property (dma_advance |->
    op_complete || $past(op_complete) || $past(op_complete, 2))
    else $error("dma_advance without completed operation");
  a_ref_after_write: assert property ($changed(ref_positive_external) |->
    $past(psel && penable && pwrite) || $past(psel && penable && pwrite, 2))
    else $error("reference changed without write");
endmodule

bind adc_seq adc_seq_assertions u_chk
(
  .clk                  (clk),
  .reset_n              (reset_n),
  .psel                 (psel),
  .penable              (penable),
  .pwrite               (pwrite),
  .pready               (pready),
  .pslverr              (pslverr),
  .sample_hold_sampling (sample_hold_sampling),
  .convert_active       (convert_active),
  .op_complete          (op_complete),
  .dma_advance          (dma_advance),
  .ref_positive_external(ref_positive_external)
);

// file: sim/adc_seq_tb_top.sv
`timescale 1ns/1ps
module adc_seq_tb_top;
  typedef struct packed
  {
    logic        w;
    logic [11:0] a;
    logic [15:0] d;
    logic        e;
  } row_t;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'H000;
  logic [31:0] pwdata = 32'H0;
  logic        trig = 1'b0;
  logic [3:0]  strb = 4'HF;
  logic        pready, pslverr, cva, sel_b, scan, rp, rn, csrc, opc, adv, half;
  logic [31:0] prdata, rd;
  logic [3:0]  shs;
  logic [1:0]  cch, mx;
  logic        er, multi;
  int          num_errors = 0;
  int          n_compared = 0;
  int          n_adv = 0;
  int          cyc = 0;
  int          base, n;
  row_t        rows [17] = '{
    '{1'b0,12'H000,16'H0000,1'b0}, '{1'b0,12'H004,16'H0000,1'b0},
    '{1'b0,12'H008,16'H0000,1'b0}, '{1'b1,12'H008,16'HFFFF,1'b0},
    '{1'b0,12'H008,16'HFFFF,1'b0}, '{1'b1,12'H004,16'HFFFF,1'b0},
    '{1'b0,12'H004,16'HE73F,1'b0}, '{1'b1,12'H00C,16'HFFFF,1'b1},
    '{1'b0,12'H00C,16'H0000,1'b1}, '{1'b1,12'H000,16'H04E9,1'b0},
    '{1'b0,12'H000,16'H04E0,1'b0}, '{1'b0,12'H004,16'HE43F,1'b0},
    '{1'b1,12'H000,16'H00E8,1'b0}, '{1'b0,12'H000,16'H00E8,1'b0},
    '{1'b0,12'H004,16'HE73F,1'b0}, '{1'b1,12'H004,16'H0000,1'b0},
    '{1'b1,12'H008,16'H0000,1'b0}};

  always #10 clk = ~clk;

  adc_seq u_dut
  (
    .clk                  (clk),
    .reset_n              (reset_n),
    .psel                 (psel),
    .penable              (penable),
    .pwrite               (pwrite),
    .paddr                (paddr),
    .pwdata               (pwdata),
    .pstrb                (strb),
    .pready               (pready),
    .prdata               (prdata),
    .pslverr              (pslverr),
    .conversion_trigger   (trig),
    .sample_hold_sampling (shs),
    .convert_active       (cva),
    .convert_channel      (cch),
    .select_sample_b      (sel_b),
    .scan_active          (scan),
    .ref_positive_external(rp),
    .ref_negative_external(rn),
    .conversion_clock_source(csrc),
    .op_complete          (opc),
    .dma_advance          (adv),
    .buffer_half_status   (half)
  );

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (adv === 1'b1) n_adv <= n_adv + 1;
    if (cyc == 20000)
    begin
      num_errors++;
      end_of_test();
    end
  end

  // ----------------------------
  // bus and check helpers
  // ----------------------------
  task automatic end_of_test();
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      $display("BAD %s exp %h got %h", nm, e, g);
      num_errors++;
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d,
                     output logic [31:0] r, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'H0000, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    apb(1'b1, a, d, rd, er);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [15:0] x);
    apb(1'b0, a, 16'H0000, rd, er);
    chk("reg", {16'H0000, x}, rd);
  endtask

  task automatic wt_done();
    n = 0;
    while (opc !== 1'b1 && n < 400)
    begin
      @(posedge clk);
      n++;
      if (cva === 1'b1 && cch > mx) mx = cch;
      if ($countones(shs) > 1) multi = 1'b1;
    end
    chk("op_complete", 1, {31'H0, opc});
  endtask

  task automatic run_seq(input logic [1:0] k, input logic s);
    mx = 2'H0;
    multi = 1'b0;
    wr(12'H004, {6'H00, k, 8'H00});
    wr(12'H000, {12'H000, s, 3'H2});
    repeat (3) @(posedge clk);
    chk("mask", s ? (k == 0 ? 1 : k == 1 ? 3 : 15) : 1, {28'H0, shs});
    wr(12'H000, {12'H000, s, 3'H0});
    wt_done();
    chk("channels", k == 0 ? 0 : k == 1 ? 1 : 3, {30'H0, mx});
    if (!s) chk("together", 0, {31'H0, multi});
    repeat (3) @(posedge clk);
    chk("alt_b", 0, {31'H0, sel_b});
    chk("half", 0, {31'H0, half});
    rdc(12'H000, {12'H000, s, 3'H1});
    wr(12'H000, {12'H000, s, 3'H1});
    rdc(12'H000, {12'H000, s, 3'H1});
    wr(12'H000, {12'H000, s, 3'H0});
    rdc(12'H000, {12'H000, s, 3'H0});
    chk("idle", 0, {28'H0, shs});
  endtask

  // ----------------------------
  // main sequence
  // ----------------------------
  initial
  begin
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    foreach (rows[i])
    begin
      apb(rows[i].w, rows[i].a, rows[i].d, rd, er);
      if (!rows[i].w) chk("read", {16'H0000, rows[i].d}, rd);
      chk("slverr", {31'H0, rows[i].e}, {31'H0, er});
    end
    strb <= 4'H1;
    wr(12'H008, 16'HFFFF);
    strb <= 4'HF;
    rdc(12'H008, 16'H00FF);
    wr(12'H000, 16'H0000);
    for (int k = 0; k < 8; k++)
    begin
      run_seq(k[2:1], k[0]);
    end
    for (int v = 0; v < 8; v++)
    begin
      wr(12'H004, {v[2:0], 13'H0000});
      @(posedge clk);
      chk("ref", v[2] ? 0 : v[1:0], {30'H0, rn, rp});
    end
    wr(12'H008, 16'H8000);
    @(posedge clk);
    chk("clk_src", 1, {31'H0, csrc});
    wr(12'H004, 16'H040B);
    wr(12'H000, 16'H0026);
    wr(12'H000, 16'H0024);
    rdc(12'H000, 16'H0026);
    base = n_adv;
    for (int i = 0; i < 6; i++)
    begin
      n = 0;
      while (shs === 4'H0 && n < 100)
      begin
        @(posedge clk);
        n++;
      end
      chk("auto_start", 1, {31'H0, |shs});
      chk("alt_b", i % 2, {31'H0, sel_b});
      chk("scan", 1 - i % 2, {31'H0, scan});
      trig <= 1'b1;
      repeat (4) @(posedge clk);
      trig <= 1'b0;
      rdc(12'H000, 16'H0024);
      wt_done();
      repeat (3) @(posedge clk);
      chk("advance", (i + 1) / 3, n_adv - base);
      chk("half", ((i + 1) / 3) % 2, {31'H0, half});
    end
    wr(12'H000, 16'H0020);
    trig <= 1'b1;
    repeat (4) @(posedge clk);
    trig <= 1'b0;
    wt_done();
    repeat (10) @(posedge clk);
    chk("stop", 0, {28'H0, shs});
    wr(12'H000, 16'H0002);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk("in_reset", 0, {25'H0, shs, cva, opc, pready});
    reset_n <= 1'b1;
    @(posedge clk);
    rdc(12'H000, 16'H0000);
    rdc(12'H004, 16'H0000);
    end_of_test();
  end
endmodule
